// file: hdl/lcc_map.svh
// Register offsets, field positions and reset values of the link capability registers.
// Assumes inclusion by the register bank module only.
// What this block does
// R1 - Max incoming and outgoing link width fields read constant 000, 8-bit.
// R2 - Double-word flow control capability and enable bits always read zero.
// R3 - Actual incoming and outgoing link width fields read constant 000.
// R4 - Specification revision register reads constant 0x13; writes ignored.
// R5 - Transmit clock is four times quarter receive clock or reference clock.
// R6 - Four-bit link frequency field writable, cold-reset to 0, no internal effect.
// R7 - Protocol error set when control line changes off a 4-byte boundary; read-clear, cold.
// R8 - Overflow error set when packet arrives with receive buffer full; read-clear, cold.
// R9 - End-of-chain error set when posted request or response given to transmitter.
// R10 - Control timeout bit writable, warm reset: 0 is one millisecond, 1 one second.
// R11 - Supported frequency field fixed from receive clock period parameter.
// R12 - Feature bits 0 to 3 read zero, bit 7 reads one.
// R13 - Enumeration scratch pad not implemented; reads zero.
// R14 - Protocol error flood enable makes protocol errors cause a sync flood.
// R15 - Overflow flood enable makes overflow errors cause a sync flood.
// R16 - All error interrupt enable bits of error handling read zero.
// R17 - Chain fail set on sync flood detected or flood-causing error; warm reset.
// R18 - Response error set when link receives response error; read-clear, cold.
// R19 - Memory base and limit upper registers read zero.
// R20 - Only link 0 registers used; link 1 counterparts reserved, read zero.
// R21 - Configuration accesses accepted only from link 0.
// R22 - Cold-reset bits survive warm reset; warm-reset bits clear on either reset.
`ifndef LCC_MAP_SVH
`define LCC_MAP_SVH
// ------------------------------------------------------------
// Byte offsets
// ------------------------------------------------------------
`define LCC_OFF_LINK_CFG0   8'h46
`define LCC_OFF_LINK_CFG1   8'h4a
`define LCC_OFF_SPEC_REV    8'h4c
`define LCC_OFF_LINK_ERR0   8'h4d
`define LCC_OFF_FREQ_CAP0   8'h4e
`define LCC_OFF_FEATURE     8'h50
`define LCC_OFF_LINK_ERR1   8'h51
`define LCC_OFF_FREQ_CAP1   8'h52
`define LCC_OFF_SCRATCH     8'h54
`define LCC_OFF_ERR_HANDLE  8'h56
`define LCC_OFF_MEM_UPPER   8'h58
// ------------------------------------------------------------
// Constant values and fields
// ------------------------------------------------------------
`define LCC_LINK_CFG_VAL    16'h0000
`define LCC_SPEC_REV_VAL    8'h13
`define LCC_FEATURE_VAL     8'h80
`define LCC_FREQ_CAP_5000   16'h0001
`define LCC_FREQ_CAP_3333   16'h0003
`define LCC_FREQ_CAP_2500   16'h0007
`define LCC_FREQ_CAP_2000   16'h000f
`define LCC_ERR_FREQ_MSB    3
`define LCC_ERR_PROTO_BIT   4
`define LCC_ERR_OVFL_BIT    5
`define LCC_ERR_EOC_BIT     6
`define LCC_ERR_CTLTO_BIT   7
`define LCC_EH_PFLOOD_BIT   0
`define LCC_EH_OFLOOD_BIT   1
`define LCC_EH_CHFAIL_BIT   8
`define LCC_EH_RSPERR_BIT   9
`define LCC_BOUNDARY_BYTES  2'h3
// Timeout times and counts at a 10 MHz clock
`define LCC_CLK_NS          100
`define LCC_TO_SHORT_NS     1000000
`define LCC_TO_LONG_NS      1000000000
`endif

// file: hdl/lcc_pkg.sv
// Types shared by the link capability register bank.
// Assumes the map header defines all numeric constants.
package lcc_pkg;
   // Configuration access from a link
   typedef struct packed {
      logic       req;
      logic       wr;
      logic       link;
      logic [7:0] addr;
      logic [1:0] be;
      logic [15:0] wdata;
   } lcc_cfg_req_t;
   // Receive-side error events
   typedef struct packed {
      logic ctlChange;
      logic overflow;
      logic eocPosted;
      logic respError;
      logic floodSeen;
   } lcc_rx_evt_t;
   typedef enum logic [2:0] {
      LCC_TO_IDLE  = 3'b001,
      LCC_TO_COUNT = 3'b010,
      LCC_TO_FIRED = 3'b100
   } lcc_to_state_t;
endpackage

// file: hdl/lcc_csr.sv
// Link capability configuration registers of an 8-bit end-chain link.
// Assumes 16-bit aligned accesses on link 0, one cycle per request, inputs synchronous.
`timescale 1ns/1ps
`include "lcc_map.svh"
module lcc_csr #(
   parameter int  RX_PERIOD_PS   = 2500,
   parameter bit  SHARED_REF_TX  = 1'b0,
   parameter int  TO_SHORT_CYC   = `LCC_TO_SHORT_NS / `LCC_CLK_NS,
   parameter int  TO_LONG_CYC    = `LCC_TO_LONG_NS / `LCC_CLK_NS
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire logic                 warmRst_n,
   input  wire lcc_pkg::lcc_cfg_req_t cfgReq,
   input  wire lcc_pkg::lcc_rx_evt_t  rxEvt,
   input  wire logic                 rx_control_in,
   input  wire logic                 rxCtlPhase,
   input  wire logic                 rx_link_clock_quarter,
   input  wire logic                 reference_clock_in,
   output logic [15:0]               cfgRdata,
   output logic                      cfgAck,
   output logic                      syncFlood,
   output logic                      txClkRefSel,
   output logic                      txClkBase
);
   import lcc_pkg::*;

   // ------------------------------------------------------------
   // Reset synchronisers
   // ------------------------------------------------------------
   logic coldMeta_ff, coldRst_n_ff, warmMeta_ff, warmRst_n_ff;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         coldMeta_ff  <= 1'b0;
         coldRst_n_ff <= 1'b0;
      end else begin
         coldMeta_ff  <= 1'b1;
         coldRst_n_ff <= coldMeta_ff;
      end
   end
   // Warm reset also asserts on cold reset [R22]
   wire logic warmAny_n = rst_n & warmRst_n;
   always_ff @(posedge core_clk or negedge warmAny_n) begin
      if (!warmAny_n) begin
         warmMeta_ff  <= 1'b0;
         warmRst_n_ff <= 1'b0;
      end else begin
         warmMeta_ff  <= 1'b1;
         warmRst_n_ff <= warmMeta_ff;
      end
   end

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   // Link 1 requests are ignored entirely [R21]
   wire logic acc   = cfgReq.req & ~cfgReq.link;
   wire logic wrAcc = acc & cfgReq.wr;
   wire logic rdAcc = acc & ~cfgReq.wr;

   // Byte lane hit on a halfword pair
   function automatic logic laneHit(input logic [7:0] a, input logic [1:0] be, input logic [7:0] off);
      laneHit = (a == {off[7:1], 1'b0}) && be[off[0]];
   endfunction

   wire logic errRd  = rdAcc && laneHit(cfgReq.addr, cfgReq.be, `LCC_OFF_LINK_ERR0);
   wire logic errWr  = wrAcc && laneHit(cfgReq.addr, cfgReq.be, `LCC_OFF_LINK_ERR0);
   wire logic ehRd   = rdAcc && (cfgReq.addr == `LCC_OFF_ERR_HANDLE) && cfgReq.be[1];
   wire logic ehWr   = wrAcc && (cfgReq.addr == `LCC_OFF_ERR_HANDLE) && cfgReq.be[0];

   // ------------------------------------------------------------
   // Protocol error detection on the control line
   // ------------------------------------------------------------
   logic       ctlPrev_ff;
   logic [1:0] bytePos_ff;
   always_ff @(posedge core_clk or negedge coldRst_n_ff) begin
      if (!coldRst_n_ff) begin
         ctlPrev_ff <= 1'b0;
         bytePos_ff <= 2'h0;
      end else begin
         ctlPrev_ff <= rx_control_in;
         bytePos_ff <= rxCtlPhase ? 2'h0 : bytePos_ff + 2'h1;
      end
   end
   // Change anywhere but the start of a 4-byte group is illegal [R7]
   wire logic ctlMisalign = (rx_control_in != ctlPrev_ff) && (bytePos_ff != 2'h0) && !rxCtlPhase;

   // Control-low timeout, length picked by the warm-reset select bit [R10]
   logic          ctlToSel_ff;
   lcc_to_state_t toState_ff;
   logic [31:0]   toCnt_ff;
   wire logic [31:0] toLimit = ctlToSel_ff ? 32'(TO_LONG_CYC) : 32'(TO_SHORT_CYC);
   always_ff @(posedge core_clk or negedge warmRst_n_ff) begin
      if (!warmRst_n_ff) begin
         toState_ff <= LCC_TO_IDLE;
         toCnt_ff   <= 32'h0;
      end else begin
         case (toState_ff)
            LCC_TO_IDLE: begin
               toCnt_ff <= 32'h1;
               if (!rx_control_in) toState_ff <= LCC_TO_COUNT;
            end
            LCC_TO_COUNT: begin
               toCnt_ff <= toCnt_ff + 32'h1;
               if (rx_control_in) toState_ff <= LCC_TO_IDLE;
               else if (toCnt_ff >= toLimit) toState_ff <= LCC_TO_FIRED;
            end
            LCC_TO_FIRED: begin
               if (rx_control_in) toState_ff <= LCC_TO_IDLE;
            end
            default: toState_ff <= LCC_TO_IDLE;
         endcase
      end
   end
   wire logic ctlTimeout = (toState_ff == LCC_TO_COUNT) && !rx_control_in && (toCnt_ff >= toLimit);
   wire logic protoEvt   = ctlMisalign | ctlTimeout;

   // ------------------------------------------------------------
   // Link error register and response error flag: cold-reset bits [R22]
   // ------------------------------------------------------------
   logic [3:0] linkFreq_ff;
   logic       protoErr_ff, ovflErr_ff, eocErr_ff, rspErr_ff;
   // Stored only; the transmit clock ignores it [R6]
   always_ff @(posedge core_clk or negedge coldRst_n_ff) begin
      if (!coldRst_n_ff) linkFreq_ff <= 4'h0;
      else if (errWr)
         linkFreq_ff <= cfgReq.wdata[8 +: (`LCC_ERR_FREQ_MSB + 1)];
   end
   // Read-clear flags; a new event in the read cycle wins
   always_ff @(posedge core_clk or negedge coldRst_n_ff) begin
      if (!coldRst_n_ff) begin
         protoErr_ff <= 1'b0;
         ovflErr_ff  <= 1'b0;
         eocErr_ff   <= 1'b0;
         rspErr_ff   <= 1'b0;
      end else begin
         protoErr_ff <= protoEvt | (protoErr_ff & ~errRd);            // [R7]
         ovflErr_ff  <= rxEvt.overflow | (ovflErr_ff & ~errRd);       // [R8]
         eocErr_ff   <= rxEvt.eocPosted | (eocErr_ff & ~errRd);       // [R9]
         rspErr_ff   <= rxEvt.respError | (rspErr_ff & ~ehRd);        // [R18]
      end
   end

   // ------------------------------------------------------------
   // Warm-reset control and chain fail
   // ------------------------------------------------------------
   logic pFloodEn_ff, oFloodEn_ff, chainFail_ff;
   always_ff @(posedge core_clk or negedge warmRst_n_ff) begin
      if (!warmRst_n_ff) begin
         ctlToSel_ff <= 1'b0;
         pFloodEn_ff <= 1'b0;
         oFloodEn_ff <= 1'b0;
      end else begin
         if (errWr) ctlToSel_ff <= cfgReq.wdata[8 + `LCC_ERR_CTLTO_BIT];   // [R10]
         if (ehWr) begin
            pFloodEn_ff <= cfgReq.wdata[`LCC_EH_PFLOOD_BIT];               // [R14]
            oFloodEn_ff <= cfgReq.wdata[`LCC_EH_OFLOOD_BIT];               // [R15]
         end
      end
   end
   wire logic floodCause = (protoEvt & pFloodEn_ff) | (rxEvt.overflow & oFloodEn_ff); // [R14] [R15]
   // Sticky until warm reset; no software clear [R17]
   always_ff @(posedge core_clk or negedge warmRst_n_ff) begin
      if (!warmRst_n_ff) begin
         chainFail_ff <= 1'b0;
         syncFlood    <= 1'b0;
      end else begin
         chainFail_ff <= chainFail_ff | floodCause | rxEvt.floodSeen;
         syncFlood    <= syncFlood | floodCause;
      end
   end

   // ------------------------------------------------------------
   // Transmit clock source
   // ------------------------------------------------------------
   // Multiply-by-four happens in the PLL outside; here only the base is picked [R5]
   assign txClkRefSel = SHARED_REF_TX;
   assign txClkBase   = SHARED_REF_TX ? reference_clock_in : rx_link_clock_quarter;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   function automatic logic [15:0] freqCap(input int period);
      case (period)
         5000:    freqCap = `LCC_FREQ_CAP_5000;
         3333:    freqCap = `LCC_FREQ_CAP_3333;
         2000:    freqCap = `LCC_FREQ_CAP_2000;
         default: freqCap = `LCC_FREQ_CAP_2500;
      endcase
   endfunction
   localparam logic [15:0] FREQ_CAP = freqCap(RX_PERIOD_PS); // [R11]

   logic [15:0] rdMux;
   always_comb begin
      rdMux = 16'h0000;
      case (cfgReq.addr)
         `LCC_OFF_LINK_CFG0:  rdMux = `LCC_LINK_CFG_VAL;  // [R1] [R2] [R3]
         `LCC_OFF_SPEC_REV:   rdMux = {ctlToSel_ff, eocErr_ff, ovflErr_ff, protoErr_ff,
                                       linkFreq_ff, `LCC_SPEC_REV_VAL}; // [R4]
         `LCC_OFF_FREQ_CAP0:  rdMux = FREQ_CAP;                       // [R11]
         `LCC_OFF_FEATURE:    rdMux = {8'h00, `LCC_FEATURE_VAL};      // [R12] [R20]
         `LCC_OFF_FREQ_CAP1,
         `LCC_OFF_LINK_CFG1:  rdMux = 16'h0000;                       // [R20]
         `LCC_OFF_SCRATCH:    rdMux = 16'h0000;                       // [R13]
         `LCC_OFF_ERR_HANDLE: rdMux = {6'h00, rspErr_ff, chainFail_ff, 6'h00, oFloodEn_ff, pFloodEn_ff}; // [R16]
         `LCC_OFF_MEM_UPPER:  rdMux = 16'h0000;                       // [R19]
         default:             rdMux = 16'h0000;
      endcase
   end
   // Registered answer, one cycle after the request
   always_ff @(posedge core_clk or negedge coldRst_n_ff) begin
      if (!coldRst_n_ff) begin
         cfgRdata <= 16'h0000;
         cfgAck   <= 1'b0;
      end else begin
         cfgRdata <= rdAcc ? rdMux : 16'h0000;
         cfgAck   <= acc;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!coldRst_n_ff);
   proto_set_a: assert property (ctlMisalign |=> protoErr_ff) else $error("protocol error not set"); // [R7]
   ovfl_set_a: assert property (rxEvt.overflow |=> ovflErr_ff) else $error("overflow not set"); // [R8]
   eoc_set_a: assert property (rxEvt.eocPosted |=> eocErr_ff) else $error("end of chain not set"); // [R9]
   rsp_set_a: assert property (rxEvt.respError |=> rspErr_ff) else $error("response error not set"); // [R18]
   rev_read_a: assert property (rdAcc && cfgReq.addr == `LCC_OFF_SPEC_REV |=> cfgRdata[7:0] == `LCC_SPEC_REV_VAL)
      else $error("revision wrong"); // [R4]
   cfg_zero_a: assert property (rdAcc && cfgReq.addr == `LCC_OFF_LINK_CFG0 |=> cfgRdata == 16'h0000)
      else $error("link config nonzero"); // [R1]
   link1_ign_a: assert property (cfgReq.req && cfgReq.link |=> !cfgAck) else $error("link 1 access taken"); // [R21]
   pflood_a: assert property (disable iff (!warmRst_n_ff) protoEvt && pFloodEn_ff |=> syncFlood && chainFail_ff)
      else $error("no flood on protocol error"); // [R14]
   oflood_a: assert property (disable iff (!warmRst_n_ff) rxEvt.overflow && oFloodEn_ff |=> syncFlood)
      else $error("no flood on overflow"); // [R15]
   freq_cap_a: assert property (rdAcc && cfgReq.addr == `LCC_OFF_FREQ_CAP0 |=> cfgRdata == FREQ_CAP)
      else $error("frequency capability wrong"); // [R11]
   proto_rd_c: cover property (protoErr_ff ##1 errRd);
   flood_c: cover property (floodCause);
   to_c: cover property (ctlTimeout);
endmodule

// file: dv/tb_link_capability_csr.sv
// Self-checking bench for the link capability register bank.
// Assumes lcc_pkg and lcc_csr are compiled first; the design's own assertions run inside it.
`timescale 1ns/1ps
module tb_link_capability_csr;
   import lcc_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic          core_clk              = 1'b0;
   logic          rst_n                 = 1'b0;
   logic          warmRst_n             = 1'b0;
   lcc_cfg_req_t  cfgReq                = '0;
   lcc_rx_evt_t   rxEvt                 = '0;
   logic          rx_control_in         = 1'b1;
   logic          rxCtlPhase            = 1'b1;
   logic          rx_link_clock_quarter = 1'b0;
   logic          reference_clock_in    = 1'b1;
   logic [15:0]   cfgRdata;
   logic          cfgAck;
   logic          syncFlood;
   logic          txClkRefSel;
   logic          txClkBase;
   int            error_cnt             = 0;
   int            samples_checked       = 0;
   int            cycles                = 0;
   lcc_rx_evt_t   noEvt                 = '0;

   // Short timeouts keep the control line waits to a few cycles
   lcc_csr #(.RX_PERIOD_PS(2500), .SHARED_REF_TX(1'b0), .TO_SHORT_CYC(8), .TO_LONG_CYC(20)) u_lcc_csr (
      .core_clk              (core_clk),
      .rst_n                 (rst_n),
      .warmRst_n             (warmRst_n),
      .cfgReq                (cfgReq),
      .rxEvt                 (rxEvt),
      .rx_control_in         (rx_control_in),
      .rxCtlPhase            (rxCtlPhase),
      .rx_link_clock_quarter (rx_link_clock_quarter),
      .reference_clock_in    (reference_clock_in),
      .cfgRdata              (cfgRdata),
      .cfgAck                (cfgAck),
      .syncFlood             (syncFlood),
      .txClkRefSel           (txClkRefSel),
      .txClkBase             (txClkBase)
   );

   // ------------------------------------------------------------
   // Clock, hang guard and shared tasks
   // ------------------------------------------------------------
   always #50 core_clk = ~core_clk;

   // Whole run is well under a thousand cycles; a hang ends it here
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One request, taken at the next edge; answer sampled once that edge has landed
   task automatic acc(input logic wr, input logic lnk, input logic [7:0] a, input logic [1:0] be,
                      input logic [15:0] wd, output logic ack, output logic [15:0] rd);
      @(posedge core_clk);
      cfgReq <= '{req: 1'b1, wr: wr, link: lnk, addr: a, be: be, wdata: wd};
      @(posedge core_clk);
      cfgReq.req <= 1'b0;
      #1;
      ack = cfgAck;
      rd = cfgRdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      logic        k;
      logic [15:0] d;
      acc(1'b0, 1'b0, a, 2'b11, 16'h0000, k, d);
      chk({15'h0000, k}, 16'h0001);
      chk(d, exp);
   endtask

   task automatic wrc(input logic [7:0] a, input logic [1:0] be, input logic [15:0] wd);
      logic        k;
      logic [15:0] d;
      acc(1'b1, 1'b0, a, be, wd, k, d);
      chk({15'h0000, k}, 16'h0001);
   endtask

   task automatic ev(input lcc_rx_evt_t e);
      @(posedge core_clk);
      rxEvt <= e;
      @(posedge core_clk);
      rxEvt <= noEvt;
      repeat (2) @(posedge core_clk);
   endtask

   // Control line low for n cycles; phase low makes the return high land off a group boundary
   task automatic ctlLow(input int n, input logic ph);
      @(posedge core_clk);
      rxCtlPhase <= ph;
      rx_control_in <= 1'b0;
      repeat (n) @(posedge core_clk);
      rx_control_in <= 1'b1;
      @(posedge core_clk);
      rxCtlPhase <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask

   task automatic pulseRst(input logic cold);
      @(posedge core_clk);
      if (cold) rst_n <= 1'b0;
      else warmRst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      warmRst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Fixed registers, reserved link 1 copies, writes to read-only places
   task automatic t_const();
      wrc(8'h46, 2'b11, 16'hffff);
      wrc(8'h58, 2'b11, 16'hffff);
      rdc(8'h46, 16'h0000);
      rdc(8'h4c, 16'h0013);
      rdc(8'h4e, 16'h0007);
      rdc(8'h50, 16'h0080);
      rdc(8'h4a, 16'h0000);
      rdc(8'h52, 16'h0000);
      rdc(8'h54, 16'h0000);
      rdc(8'h56, 16'h0000);
      rdc(8'h58, 16'h0000);
   endtask

   // Writable fields, then a warm reset that keeps only cold bits
   task automatic t_write();
      wrc(8'h4c, 2'b11, 16'h8fff);
      rdc(8'h4c, 16'h8f13);
      wrc(8'h56, 2'b11, 16'hffff);
      rdc(8'h56, 16'h0003);
      pulseRst(1'b0);
      rdc(8'h4c, 16'h0f13);
      rdc(8'h56, 16'h0000);
   endtask

   // Configuration traffic on link 1 is never answered nor applied
   task automatic t_link1();
      logic        k;
      logic [15:0] d;
      acc(1'b1, 1'b1, 8'h4c, 2'b10, 16'h0500, k, d);
      chk({15'h0000, k}, 16'h0000);
      acc(1'b0, 1'b1, 8'h4c, 2'b11, 16'h0000, k, d);
      chk({15'h0000, k}, 16'h0000);
      rdc(8'h4c, 16'h0f13);
   endtask

   // Status events set their bits once, cleared by the read except chain fail; no flood while disabled
   task automatic t_events();
      ev('{ctlChange: 1'b0, overflow: 1'b1, eocPosted: 1'b0, respError: 1'b0, floodSeen: 1'b0});
      chk({15'h0000, syncFlood}, 16'h0000);
      rdc(8'h4c, 16'h2f13);
      rdc(8'h4c, 16'h0f13);
      ev('{ctlChange: 1'b0, overflow: 1'b0, eocPosted: 1'b1, respError: 1'b0, floodSeen: 1'b0});
      rdc(8'h4c, 16'h4f13);
      ev('{ctlChange: 1'b0, overflow: 1'b0, eocPosted: 1'b0, respError: 1'b1, floodSeen: 1'b0});
      rdc(8'h56, 16'h0200);
      rdc(8'h56, 16'h0000);
      ctlLow(2, 1'b0);
      rdc(8'h4c, 16'h1f13);
      rdc(8'h4c, 16'h0f13);
      ev('{ctlChange: 1'b0, overflow: 1'b0, eocPosted: 1'b0, respError: 1'b0, floodSeen: 1'b1});
      rdc(8'h56, 16'h0100);
      pulseRst(1'b0);
   endtask

   // Flood enables, timeout lengths and the reset domains of the sticky state
   task automatic t_flood();
      wrc(8'h56, 2'b01, 16'h0002);
      ev('{ctlChange: 1'b0, overflow: 1'b1, eocPosted: 1'b0, respError: 1'b0, floodSeen: 1'b0});
      chk({15'h0000, syncFlood}, 16'h0001);
      rdc(8'h56, 16'h0102);
      pulseRst(1'b0);
      chk({15'h0000, syncFlood}, 16'h0000);
      rdc(8'h4c, 16'h2f13);
      wrc(8'h56, 2'b01, 16'h0001);
      ctlLow(12, 1'b1);
      chk({15'h0000, syncFlood}, 16'h0001);
      rdc(8'h4c, 16'h1f13);
      pulseRst(1'b1);
      chk({15'h0000, syncFlood}, 16'h0000);
      rdc(8'h4c, 16'h0013);
      wrc(8'h4c, 2'b10, 16'h8000);
      ctlLow(12, 1'b1);
      rdc(8'h4c, 16'h8013);
      ctlLow(30, 1'b1);
      rdc(8'h4c, 16'h9013);
   endtask

   // Transmit clock base follows the quarter receive clock in this option
   task automatic t_clk();
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk);
         rx_link_clock_quarter <= i[0];
         reference_clock_in <= ~i[0];
         #1;
         chk({15'h0000, txClkBase}, {15'h0000, i[0]});
         chk({15'h0000, txClkRefSel}, 16'h0000);
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      warmRst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_const();
      t_write();
      t_link1();
      t_events();
      t_flood();
      t_clk();
      final_report();
   end
endmodule
